// File: rtl/pms_sequencer.sv
// Summary of operation
// [RL1] no fast wake-up from deep sleep zero when watchdog is disabled
// [RL2] clock select 0 with divider 000 or 001 moves to slow mode
// [RL3] slow mode needs low oscillator stable, shown by low ready flag
// [RL4] clock select 1, or divider 010 to 111, runs fast mode
// [RL5] software checks high ready flag before relying on fast clock
// [RL6] low-speed system clock stops high oscillator and its /16, /64 clocks
// [RL7] halt, idle off, watchdog and detector off: deep sleep zero, clocks stop
// [RL8] deep sleep zero clears and stops the watchdog counter
// [RL9] halt, idle off, watchdog or detector on: sleep one on subsidiary clock
// [RL10] sleep one clears watchdog and resumes it when on subsidiary clock
// [RL11] halt, idle on, keep-alive off: idle zero, system clock stops
// [RL12] idle zero resumes watchdog on subsidiary clock, stops it on system clock
// [RL13] halt, idle on, keep-alive on: idle one, all clocks run
// [RL14] idle one clears and resumes an enabled watchdog on either source
// [RL15] halt modes keep memory, registers and ports unchanged
// [RL16] any halt entry sets power-down flag and clears time-out flag
// [RL17] crystal fast wake runs subsidiary clock for 1024 cycles, then crystal
// [RL18] power-up or clear-watchdog command clears power-down flag
// [RL19] operating mode kept as explicit state, gating changes on transitions
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module pms_sequencer
	import pms_pkg::*;
#(
	parameter int HXT_STAB = PMS_HXT_STAB_CYC,
	parameter int LXT_STAB = PMS_LXT_STAB_CYC
)(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// oscillator ticks from the analogue side
	input  wire logic        hxt_tick,
	input  wire logic        low_tick,
	// clock gating outputs
	output logic             sysclk_en,
	output logic             high_osc_en,
	output logic             high_div_en,
	output logic             sub_clk_en,
	output logic             timebase_en,
	output logic             sys_from_low,
	output logic             cpu_halted,
	output logic             wdt_clk_en,
	output logic             wdt_clear,
	// interrupt
	output logic             irq
);

	initial
	begin
		if (HXT_STAB < 1 || HXT_STAB > 65535 || LXT_STAB < 1 || LXT_STAB > 65535)
			$error("pms_sequencer: stabilisation count out of range");
	end

	// register state
	logic [7:0]  mode_ctrl_reg;
	logic [7:0]  wdt_ctrl_reg;
	logic        low_osc_ready_flag;
	logic        high_osc_ready_flag;
	logic        power_down_flag;
	logic        watchdog_timeout_flag;
	logic [2:0]  irq_stat_reg;
	logic [2:0]  irq_mask_reg;
	pms_mode_t   mode_reg;
	pms_mode_t   mode_next;
	logic [15:0] hstab_reg;
	logic [15:0] lstab_reg;
	logic        fast_wake_reg;

	// field aliases
	logic       hi_lo_clock_select;
	logic [2:0] clock_divider_field;
	logic       idle_enable_bit;
	logic       fast_wake_enable_bit;
	logic       sysclk_keepalive_bit;
	logic       wdt_on;
	logic       wdt_sub;
	logic       lvd_on;
	assign hi_lo_clock_select   = mode_ctrl_reg[PMS_MC_HILO];
	assign clock_divider_field  = mode_ctrl_reg[PMS_MC_DIV_LSB +: 3];
	assign idle_enable_bit      = mode_ctrl_reg[PMS_MC_IDLE_EN];
	assign fast_wake_enable_bit = mode_ctrl_reg[PMS_MC_FAST_WAKE];
	assign sysclk_keepalive_bit = wdt_ctrl_reg[PMS_WC_KEEPALIVE];
	assign wdt_on               = wdt_ctrl_reg[PMS_WC_EN];
	assign wdt_sub              = wdt_ctrl_reg[PMS_WC_SRC_SUB];
	assign lvd_on               = wdt_ctrl_reg[PMS_WC_LVD_EN];

	// bus handshake state
	logic [7:0]  aw_addr_reg;
	logic        aw_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        w_have_reg;
	logic        wr_go;
	logic        rd_go;
	assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	// write-side commands decoded from the command register
	logic cmd_halt;
	logic cmd_clrwdt;
	logic cmd_wake;
	logic cmd_wdto;
	logic wr_cmd;
	assign wr_cmd     = wr_go && aw_addr_reg == PMS_OFF_CMD && w_strb_reg[0];
	assign cmd_halt   = wr_cmd && w_data_reg[PMS_CMD_HALT];
	assign cmd_clrwdt = wr_cmd && w_data_reg[PMS_CMD_CLRWDT];
	assign cmd_wake   = wr_cmd && w_data_reg[PMS_CMD_WAKE];
	assign cmd_wdto   = wr_cmd && w_data_reg[PMS_CMD_WDTO];

	// write address and data captured in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_have_reg && !s_axi_awready && !wr_go;
			s_axi_wready  <= !w_have_reg && !s_axi_wready && !wr_go;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_have_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			else if (wr_go)
				w_have_reg <= 1'b0;
		end
	end

	// write response, slverr on unmapped offsets
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr_reg)
				PMS_OFF_MODE_CTRL, PMS_OFF_WDT_CTRL, PMS_OFF_CMD,
				PMS_OFF_IRQ_STAT, PMS_OFF_IRQ_MASK, PMS_OFF_STATUS,
				PMS_OFF_CLKS: s_axi_bresp <= 2'h0;
				default:      s_axi_bresp <= 2'h2;
			endcase
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// software control registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_ctrl_reg <= PMS_MC_RESET;
			wdt_ctrl_reg  <= PMS_WC_RESET;
			irq_mask_reg  <= 3'h0;
		end
		else if (wr_go && w_strb_reg[0])
		begin
			if (aw_addr_reg == PMS_OFF_MODE_CTRL)
				mode_ctrl_reg <= w_data_reg[7:0];
			if (aw_addr_reg == PMS_OFF_WDT_CTRL)
				wdt_ctrl_reg <= w_data_reg[7:0];
			if (aw_addr_reg == PMS_OFF_IRQ_MASK)
				irq_mask_reg <= w_data_reg[2:0];
		end
	end

	// mode selection from the registers and the halt command
	always_comb
	begin
		mode_next = mode_reg;
		unique case (mode_reg)
			PMS_FAST, PMS_SLOW:
			begin
				if (cmd_halt)
				begin
					if (!idle_enable_bit)
						// [RL7] [RL9] sleep choice
						mode_next = (wdt_on || lvd_on) ? PMS_SLEEP_ONE : PMS_DEEP_SLEEP_ZERO;
					else
						// [RL11] [RL13] idle choice
						mode_next = sysclk_keepalive_bit ? PMS_IDLE_ONE : PMS_IDLE_ZERO;
				end
				// [RL2] [RL3] slow needs low ready
				else if (!hi_lo_clock_select && clock_divider_field <= PMS_DIV_SLOW1
					&& low_osc_ready_flag)
					mode_next = PMS_SLOW;
				// [RL4] fast selection
				else if (hi_lo_clock_select || clock_divider_field > PMS_DIV_SLOW1)
					mode_next = PMS_FAST;
			end
			default:
			begin
				if (cmd_wake || cmd_wdto)
					mode_next = (!hi_lo_clock_select && clock_divider_field <= PMS_DIV_SLOW1
						&& low_osc_ready_flag) ? PMS_SLOW : PMS_FAST;
			end
		endcase
	end

	// [RL19] explicit mode state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_reg <= PMS_FAST;
		else
			mode_reg <= mode_next;
	end

	// high oscillator stabilisation and fast wake-up
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hstab_reg           <= 16'h0000;
			high_osc_ready_flag <= 1'b0;
			fast_wake_reg       <= 1'b0;
		end
		else if (!high_osc_en)
		begin
			hstab_reg           <= 16'h0000;
			high_osc_ready_flag <= 1'b0;
			// [RL1] fast wake only with subsidiary clock alive
			fast_wake_reg       <= fast_wake_enable_bit && mode_reg != PMS_DEEP_SLEEP_ZERO;
		end
		else if (!high_osc_ready_flag && hxt_tick)
		begin
			// [RL17] ready after the crystal count
			if (hstab_reg == 16'(HXT_STAB - 1))
			begin
				high_osc_ready_flag <= 1'b1;
				fast_wake_reg       <= 1'b0;
			end
			hstab_reg <= hstab_reg + 16'h0001;
		end
	end

	// low oscillator stabilisation
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lstab_reg          <= 16'h0000;
			low_osc_ready_flag <= 1'b0;
		end
		else if (!sub_clk_en)
		begin
			lstab_reg          <= 16'h0000;
			low_osc_ready_flag <= 1'b0;
		end
		// [RL3] low ready after count
		else if (!low_osc_ready_flag && low_tick)
		begin
			if (lstab_reg == 16'(LXT_STAB - 1))
				low_osc_ready_flag <= 1'b1;
			lstab_reg <= lstab_reg + 16'h0001;
		end
	end

	// power-down and time-out flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			power_down_flag       <= 1'b0;
			watchdog_timeout_flag <= 1'b0;
		end
		else
		begin
			// [RL16] halt sets power-down, clears time-out
			if (cmd_halt && (mode_reg == PMS_FAST || mode_reg == PMS_SLOW))
			begin
				power_down_flag       <= 1'b1;
				watchdog_timeout_flag <= 1'b0;
			end
			else
			begin
				// [RL18] clear-watchdog clears power-down
				if (cmd_clrwdt)
					power_down_flag <= 1'b0;
				if (cmd_wdto)
					watchdog_timeout_flag <= 1'b1;
			end
		end
	end

	// clock gating, updated from the next mode on every transition
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sysclk_en    <= 1'b1;
			high_osc_en  <= 1'b1;
			high_div_en  <= 1'b1;
			sub_clk_en   <= 1'b1;
			timebase_en  <= 1'b1;
			sys_from_low <= 1'b0;
			cpu_halted   <= 1'b0;
			wdt_clk_en   <= 1'b1;
		end
		else
		begin
			// [RL15] halt only gates clocks, state is untouched
			cpu_halted   <= mode_next != PMS_FAST && mode_next != PMS_SLOW;
			// [RL7] [RL11] system clock stops in sleep and idle zero
			sysclk_en    <= mode_next == PMS_FAST || mode_next == PMS_SLOW
				|| mode_next == PMS_IDLE_ONE;
			// [RL6] low system clock stops high oscillator and dividers
			high_osc_en  <= mode_next == PMS_FAST || mode_next == PMS_IDLE_ONE;
			high_div_en  <= mode_next == PMS_FAST || mode_next == PMS_IDLE_ONE;
			// [RL17] fast wake runs from subsidiary clock until ready
			sys_from_low <= mode_next == PMS_SLOW
				|| (mode_next == PMS_FAST && fast_wake_reg && !high_osc_ready_flag);
			// [RL9] [RL11] [RL13] time-base and subsidiary clocks
			timebase_en  <= mode_next != PMS_DEEP_SLEEP_ZERO && mode_next != PMS_SLEEP_ONE;
			sub_clk_en   <= mode_next != PMS_DEEP_SLEEP_ZERO || wdt_on || lvd_on;
			// [RL8] [RL10] [RL12] [RL14] watchdog clock per mode
			unique case (mode_next)
				PMS_DEEP_SLEEP_ZERO: wdt_clk_en <= 1'b0;
				PMS_SLEEP_ONE: wdt_clk_en <= wdt_on && wdt_sub;
				PMS_IDLE_ZERO:  wdt_clk_en <= wdt_on && wdt_sub;
				default:    wdt_clk_en <= wdt_on;
			endcase
		end
	end

	// [RL8] [RL10] [RL12] [RL14] watchdog clear on halt entry
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wdt_clear <= 1'b0;
		else
			wdt_clear <= (cmd_halt && !cpu_halted) || cmd_clrwdt;
	end

	// sticky interrupt status, read clears, set wins
	logic [2:0] irq_ev;
	logic       rd_irq;
	assign irq_ev[PMS_EV_MODE] = mode_next != mode_reg;
	assign irq_ev[PMS_EV_HRDY] = high_osc_en && !high_osc_ready_flag && hxt_tick
		&& hstab_reg == 16'(HXT_STAB - 1);
	assign irq_ev[PMS_EV_LRDY] = sub_clk_en && !low_osc_ready_flag && low_tick
		&& lstab_reg == 16'(LXT_STAB - 1);
	assign rd_irq = rd_go && s_axi_araddr == PMS_OFF_IRQ_STAT;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_stat_reg <= 3'h0;
			irq          <= 1'b0;
		end
		else
		begin
			irq_stat_reg <= (rd_irq ? 3'h0 : irq_stat_reg) | irq_ev;
			irq          <= |(((rd_irq ? 3'h0 : irq_stat_reg) | irq_ev) & irq_mask_reg);
		end
	end

	// read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				s_axi_rdata  <= 32'h0000_0000;
				case (s_axi_araddr)
					PMS_OFF_MODE_CTRL: s_axi_rdata[7:0] <= mode_ctrl_reg;
					PMS_OFF_WDT_CTRL:  s_axi_rdata[7:0] <= wdt_ctrl_reg;
					PMS_OFF_STATUS:    s_axi_rdata[7:0] <= {1'b0, mode_reg,
						watchdog_timeout_flag, power_down_flag,
						high_osc_ready_flag, low_osc_ready_flag};
					PMS_OFF_CMD:       s_axi_rdata[7:0] <= 8'h00;
					PMS_OFF_IRQ_STAT:  s_axi_rdata[2:0] <= irq_stat_reg;
					PMS_OFF_IRQ_MASK:  s_axi_rdata[2:0] <= irq_mask_reg;
					PMS_OFF_CLKS:      s_axi_rdata[7:0] <= {cpu_halted, sys_from_low,
						wdt_clk_en, timebase_en, sub_clk_en, high_div_en,
						high_osc_en, sysclk_en};
					default:           s_axi_rresp <= 2'h2;
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule : pms_sequencer

// File: include/pms_pkg.sv
package pms_pkg;

	// register byte offsets
	localparam logic [7:0] PMS_OFF_MODE_CTRL = 8'h00;
	localparam logic [7:0] PMS_OFF_WDT_CTRL  = 8'h04;
	localparam logic [7:0] PMS_OFF_STATUS    = 8'h08;
	localparam logic [7:0] PMS_OFF_CMD       = 8'h0C;
	localparam logic [7:0] PMS_OFF_IRQ_STAT  = 8'h10;
	localparam logic [7:0] PMS_OFF_IRQ_MASK  = 8'h14;
	localparam logic [7:0] PMS_OFF_CLKS      = 8'h18;

	// mode control fields
	localparam int PMS_MC_FAST_WAKE = 0;
	localparam int PMS_MC_IDLE_EN   = 1;
	localparam int PMS_MC_DIV_LSB   = 5;
	localparam int PMS_MC_HILO      = 4;
	localparam logic [7:0] PMS_MC_RESET = 8'hE0;

	// watchdog control fields
	localparam int PMS_WC_KEEPALIVE = 7;
	localparam int PMS_WC_EN        = 0;
	localparam int PMS_WC_SRC_SUB   = 1;
	localparam int PMS_WC_LVD_EN    = 2;
	localparam logic [7:0] PMS_WC_RESET = 8'h03;

	// command register bits
	localparam int PMS_CMD_HALT   = 0;
	localparam int PMS_CMD_CLRWDT = 1;
	localparam int PMS_CMD_WAKE   = 2;
	localparam int PMS_CMD_WDTO   = 3;

	// status bits, mode code from bit 4; interrupt events use their own layout
	localparam int PMS_ST_LOW_RDY  = 0;
	localparam int PMS_ST_HIGH_RDY = 1;
	localparam int PMS_ST_PDF      = 2;
	localparam int PMS_ST_TO       = 3;
	localparam int PMS_ST_MODE_LSB = 4;

	// interrupt events
	localparam int PMS_EV_MODE  = 0;
	localparam int PMS_EV_HRDY  = 1;
	localparam int PMS_EV_LRDY  = 2;

	// stabilisation counts
	localparam int PMS_HXT_STAB_CYC = 1024;
	localparam int PMS_LXT_STAB_CYC = 1024;

	// divider codes that select the low-speed clock
	localparam logic [2:0] PMS_DIV_SLOW0 = 3'h0;
	localparam logic [2:0] PMS_DIV_SLOW1 = 3'h1;

	typedef enum logic [2:0] {
		PMS_FAST,
		PMS_SLOW,
		PMS_DEEP_SLEEP_ZERO,
		PMS_SLEEP_ONE,
		PMS_IDLE_ZERO,
		PMS_IDLE_ONE
	} pms_mode_t;

endpackage : pms_pkg

// File: tb/pms_osc_model.sv
`timescale 1ns/100ps
module pms_osc_model
	import pms_pkg::*;
#(
	parameter int HI_DIV = 2,
	parameter int LO_DIV = 3
)(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// oscillator enables from the sequencer
	input  wire logic high_osc_en,
	input  wire logic sub_clk_en,
	// one pulse per oscillator cycle
	output logic      hxt_tick,
	output logic      low_tick
);
	int hi_cnt;
	int lo_cnt;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !high_osc_en)
		begin
			hi_cnt   <= 0;
			hxt_tick <= 1'b0;
		end
		else
		begin
			hi_cnt   <= (hi_cnt == HI_DIV - 1) ? 0 : hi_cnt + 1;
			hxt_tick <= (hi_cnt == HI_DIV - 1);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !sub_clk_en)
		begin
			lo_cnt   <= 0;
			low_tick <= 1'b0;
		end
		else
		begin
			lo_cnt   <= (lo_cnt == LO_DIV - 1) ? 0 : lo_cnt + 1;
			low_tick <= (lo_cnt == LO_DIV - 1);
		end
	end
endmodule : pms_osc_model

// File: tb/pms_sequencer_monitor.sv
`timescale 1ns/100ps
module pms_sequencer_monitor
	import pms_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// gating outputs
	input wire logic sysclk_en,
	input wire logic high_osc_en,
	input wire logic high_div_en,
	input wire logic sub_clk_en,
	input wire logic timebase_en,
	input wire logic sys_from_low,
	input wire logic cpu_halted,
	input wire logic wdt_clk_en,
	input wire logic wdt_clear
);
	default clocking mon_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// halt entry with a running watchdog or a stopped subsidiary clock, then its clear pulse
	sequence s_halt_entry;
		$rose(cpu_halted) ##0 (wdt_clk_en || !sub_clk_en);
	endsequence
	sequence s_wdt_cleared;
		##[0:1] wdt_clear;
	endsequence

	wdt_entry_clear_a: assert property (s_halt_entry |-> s_wdt_cleared)
		else $error("watchdog not cleared on halt entry");
	deep_sleep_stop_a: assert property (cpu_halted && !sub_clk_en
		|-> !sysclk_en && !wdt_clk_en && !timebase_en)
		else $error("clock left running in deep sleep");
	sleep_sys_stop_a: assert property (cpu_halted && !timebase_en |-> !sysclk_en)
		else $error("system clock runs in sleep");
	idle_zero_sub_a: assert property (cpu_halted && !sysclk_en && timebase_en |-> sub_clk_en)
		else $error("subsidiary clock stopped in idle zero");
	idle_one_run_a: assert property (cpu_halted && sysclk_en |-> timebase_en && sub_clk_en)
		else $error("clock stopped in idle one");
	no_fast_wake_a: assert property ($fell(cpu_halted) && !$past(sub_clk_en)
		|-> !sys_from_low [*2])
		else $error("fast wake used after deep sleep");
	low_clock_on_a: assert property (sys_from_low |-> sub_clk_en)
		else $error("low clock selected while stopped");
	high_off_cause_a: assert property (!high_osc_en |-> sys_from_low || cpu_halted)
		else $error("high oscillator off in fast mode");
	div_clock_stop_a: assert property (!high_osc_en |-> !high_div_en)
		else $error("divided clocks run without high oscillator");
	mode_gating_a: assert property ($changed(sysclk_en) |-> $changed(cpu_halted))
		else $error("system clock gating changed without mode change");
endmodule : pms_sequencer_monitor

bind pms_sequencer pms_sequencer_monitor u_mon (.aclk, .aresetn, .sysclk_en, .high_osc_en,
	.high_div_en, .sub_clk_en, .timebase_en, .sys_from_low, .cpu_halted, .wdt_clk_en, .wdt_clear);

// File: tb/pms_sequencer_tb.sv
`timescale 1ns/100ps
module pms_sequencer_tb
	import pms_pkg::*;
;
	typedef struct {logic [31:0] m; logic [31:0] e; logic [1:0] r;} pms_note_t;
	// fast wake asked for in deep sleep zero and in sleep one
	localparam logic [7:0] HALT_MC [6] = '{8'hE1, 8'hE1, 8'hE0, 8'hE2, 8'hE2, 8'hE2};
	localparam logic [7:0] HALT_WC [6] = '{8'h00, 8'h03, 8'h04, 8'h03, 8'h01, 8'h83};
	// mode code, then system, time base, subsidiary and watchdog clocks
	localparam logic [6:0] HALT_EX [6] = '{7'h20, 7'h33, 7'h32, 7'h47, 7'h46, 7'h5F};
	logic        aclk, aresetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rnd, last_rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        hxt_tick, low_tick, sysclk_en, high_osc_en, high_div_en, sub_clk_en;
	logic        timebase_en, sys_from_low, cpu_halted, wdt_clk_en, wdt_clear, irq;
	int          bad_count = 0;
	int          total_checks = 0;
	pms_note_t   exp_q [$];
	pms_note_t   note;

	pms_sequencer #(.HXT_STAB(4), .LXT_STAB(4)) u_dut (.*);
	pms_osc_model u_osc (.*);

	// clock
	initial aclk = 1'b0;
	always #50 aclk = ~aclk;

	function automatic logic [31:0] pms_lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : pms_lfsr

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("Error at %0t ns: saw %h, expected %h", $time, seen, want);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// one register write, random data above the low byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		rnd = pms_lfsr(rnd);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {rnd[23:0], d};
		s_axi_wstrb <= {rnd[27:25], 1'b1};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			aw_done |= s_axi_awvalid & s_axi_awready;
			w_done |= s_axi_wvalid & s_axi_wready;
			if (aw_done) s_axi_awvalid <= 1'b0;
			if (w_done) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, 2'b00);
	endtask : wr

	// one register read, expectation noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge aclk);
		exp_q.push_back('{m, e, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		last_rd = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask : rd

	// read watcher compares against the oldest note
	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready)
		begin
			note = exp_q.pop_front();
			chk(s_axi_rdata & note.m, note.e);
			chk(s_axi_rresp, note.r);
		end
	end

	// hang guard
	initial
	begin
		repeat (5000) @(posedge aclk);
		bad_count++;
		end_of_test();
	end

	initial
	begin
		aresetn = 1'b0;
		rnd = 32'h76B6;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, write-only command, unmapped offset
		rd(PMS_OFF_MODE_CTRL, 32'hFFFFFFFF, 32'hE0, 2'b00);
		rd(PMS_OFF_WDT_CTRL, 32'hFFFFFFFF, 32'h03, 2'b00);
		rd(PMS_OFF_CMD, 32'hFFFFFFFF, 32'h0, 2'b00);
		rd(8'h40, 32'h0, 32'h0, 2'b10);
		wr(PMS_OFF_IRQ_MASK, 8'h00);
		// divider sweep with select low, then select high
		for (int i = 0; i < 9; i++)
		begin
			wr(PMS_OFF_MODE_CTRL, (i == 8) ? 8'h10 : 8'(i << 5));
			repeat (40) @(posedge aclk);
			rd(PMS_OFF_STATUS, (i < 2) ? 32'h71 : 32'h70, (i < 2) ? 32'h11 : 32'h0, 2'b00);
			chk({high_osc_en, high_div_en, sys_from_low, irq}, (i < 2) ? 4'h2 : 4'hC);
		end
		do rd(PMS_OFF_STATUS, 32'h0, 32'h0, 2'b00); while (!last_rd[PMS_ST_HIGH_RDY]);
		// unmasking shows the sticky mode change, reading clears it
		wr(PMS_OFF_IRQ_MASK, 8'h01);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		rd(PMS_OFF_IRQ_STAT, 32'h1, 32'h1, 2'b00);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		// every halt mode, entered, repeated, woken, cleared
		for (int k = 0; k < 6; k++)
		begin
			wr(PMS_OFF_MODE_CTRL, HALT_MC[k]);
			wr(PMS_OFF_WDT_CTRL, HALT_WC[k]);
			wr(PMS_OFF_CMD, 8'h01);
			rd(PMS_OFF_STATUS, 32'h7C, {HALT_EX[k][6:4], 4'h4}, 2'b00);
			chk({cpu_halted, sysclk_en, timebase_en, sub_clk_en, wdt_clk_en}, {1'b1, HALT_EX[k][3:0]});
			wr(PMS_OFF_CMD, 8'h01);
			rd(PMS_OFF_MODE_CTRL, 32'hFF, HALT_MC[k], 2'b00);
			rd(PMS_OFF_WDT_CTRL, 32'hFF, HALT_WC[k], 2'b00);
			wr(PMS_OFF_CMD, (k == 1) ? 8'h08 : 8'h04);
			while (cpu_halted) @(posedge aclk);
			chk(sys_from_low, (k == 1));
			repeat (12) @(posedge aclk);
			chk(sys_from_low, 1'b0);
			rd(PMS_OFF_STATUS, 32'h0C, (k == 1) ? 32'hC : 32'h4, 2'b00);
			wr(PMS_OFF_CMD, 8'h02);
			rd(PMS_OFF_STATUS, 32'h04, 32'h0, 2'b00);
		end
		end_of_test();
	end
endmodule : pms_sequencer_tb
